/* rtl/sap_pkg.sv */
// shared constants and types for the serial adc port sequencer
package sap_pkg;
    localparam int CLK_PERIOD_NS = 50;
    localparam int CS_FILT_NS    = 2000;
    localparam int CS_FILT_CYC   = (CS_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CONV_MAX_US   = 44;
    localparam int CONV_MAX_CYC  = (CONV_MAX_US * 1000) / CLK_PERIOD_NS;
    localparam int OSC_DIV       = 4;
    localparam int FIFO_DEPTH    = 16;

    localparam int RES_BITS  = 10;
    localparam int ADDR_BITS = 4;
    localparam int NUM_CHAN  = 5;

    localparam logic [4:0] FALL_SAMPLE = 5'h04;
    localparam logic [4:0] FALL_TEN    = 5'h0A;
    localparam logic [4:0] FALL_LONG   = 5'h10;
    localparam logic [2:0] RISE_ADDR   = 3'h4;

    localparam logic [3:0] ADDR_TEST_MID  = 4'hB;
    localparam logic [3:0] ADDR_TEST_ZERO = 4'hC;
    localparam logic [3:0] ADDR_TEST_FULL = 4'hD;
    localparam logic [9:0] RESULT_MID     = 10'h200;
    localparam logic [9:0] RESULT_ZERO    = 10'h000;
    localparam logic [9:0] RESULT_FULL    = 10'h3FF;
    localparam logic [9:0] RESULT_RESET   = 10'h000;
    localparam logic [3:0] ADDR_RESET     = 4'h0;

    // reference element select for the test conversions
    typedef enum logic [1:0] {REF_NONE, REF_MID, REF_LOW, REF_HIGH} sap_ref_t;

    typedef struct packed {
        logic [NUM_CHAN-1:0] chanSel;
        sap_ref_t            refSel;
        logic                sampleEn;
        logic                hold;
    } sap_ana_ctl_t;
endpackage : sap_pkg

/* rtl/sap_fifo.sv */
// result fifo with registered read data
`timescale 1ns/1ps
`default_nettype none
module sap_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 16
) (
    input  wire logic             clk_sys,
    input  wire logic             rstn,
    input  wire logic             wrValid,
    output logic                  wrReady,
    input  wire logic [WIDTH-1:0] wrData,
    output logic                  rdValid,
    input  wire logic             rdReady,
    output logic      [WIDTH-1:0] rdData
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] memQ [DEPTH];
    logic [AW-1:0]    wrPtrQ;
    logic [AW-1:0]    rdPtrQ;
    logic [AW:0]      cntQ;
    logic             outValidQ;
    logic [WIDTH-1:0] outDataQ;

    wire memEmpty = (cntQ == '0);
    wire push     = wrValid && wrReady;
    // output stage refills when it is empty or being drained and memory is not empty
    wire refill   = !memEmpty && (!outValidQ || rdReady);

    assign wrReady = (cntQ != (AW+1)'(DEPTH));
    assign rdValid = outValidQ;
    assign rdData  = outDataQ;

    always_ff @(posedge clk_sys) begin
        if (push)
            memQ[wrPtrQ] <= wrData;
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            wrPtrQ    <= '0;
            rdPtrQ    <= '0;
            cntQ      <= '0;
            outValidQ <= 1'b0;
            outDataQ  <= '0;
        end else begin
            if (push)
                wrPtrQ <= wrPtrQ + AW'(1);
            if (refill) begin
                rdPtrQ   <= rdPtrQ + AW'(1);
                outDataQ <= memQ[rdPtrQ];
            end
            if (refill)
                outValidQ <= 1'b1;
            else if (rdReady)
                outValidQ <= 1'b0;
            cntQ <= cntQ + (AW+1)'(push) - (AW+1)'(refill);
        end
    end
endmodule : sap_fifo
`default_nettype wire

/* rtl/sap_port_sequencer.sv */
// serial port and conversion sequencer of the 10-bit sar converter
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - select high: output floats, inputs ignored
// - select fall resets port counting
// - select level must persist ~2 us
// - select fall during conversion aborts, keeps result
// - result write is last conversion step
// - select low drives previous result msb
// - shift result msb first on falls
// - tenth fall drives output low
// - new msb at conversion end or 16th fall
// - address taken on first four rises
// - three ways a transfer starts
// - sample from fourth to tenth fall
// - internal oscillator runs conversion after tenth
// - shift logic static, any slow clock
// - eoc low at tenth, high when done
// - addresses 0..4 select five inputs
// - test codes B, C, D give fixed results
// - conversion ends within 44 us
module sap_port_sequencer #(
    parameter int FIFO_DEPTH = sap_pkg::FIFO_DEPTH,
    parameter int OSC_DIV    = sap_pkg::OSC_DIV
) (
    input  wire logic                 clk_sys,
    input  wire logic                 rstn,
    input  wire logic                 selectN,
    input  wire logic                 shiftClk,
    input  wire logic                 serialIn,
    input  wire logic                 compareIn,
    output logic                      serialOut,
    output logic                      serialOutOeN,
    output logic                      eoc,
    output sap_pkg::sap_ana_ctl_t     anaCtl,
    output logic [sap_pkg::RES_BITS-1:0] sarTrial
);
    typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_CONV, ST_TAIL} sap_state_t;

    // pin synchronisers
    logic csnMeta, csnSync, sclkMeta, sclkSync, sclkPrevQ, dinMeta, dinSync, cmpMeta, cmpSync;
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            {csnMeta, csnSync}   <= 2'h3;
            {sclkMeta, sclkSync} <= 2'h0;
            {dinMeta, dinSync}   <= 2'h0;
            {cmpMeta, cmpSync}   <= 2'h0;
            sclkPrevQ            <= 1'b0;
        end else begin
            {csnMeta, csnSync}   <= {selectN, csnMeta};
            {sclkMeta, sclkSync} <= {shiftClk, sclkMeta};
            {dinMeta, dinSync}   <= {serialIn, dinMeta};
            {cmpMeta, cmpSync}   <= {compareIn, cmpMeta};
            sclkPrevQ            <= sclkSync;
        end
    end

    logic       csLowQ;
    logic [5:0] filtCntQ;
    wire  csDiffers = (csnSync == csLowQ);
    wire  filtDone  = csDiffers && (filtCntQ == 6'(sap_pkg::CS_FILT_CYC - 1));
    wire  csFallEv  = filtDone && !csLowQ;
    wire  csRiseEv  = filtDone && csLowQ;
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            csLowQ   <= 1'b0;
            filtCntQ <= '0;
        end else begin
            filtCntQ <= (csDiffers && !filtDone) ? filtCntQ + 6'h01 : 6'h00;
            if (filtDone)
                csLowQ <= !csLowQ;
        end
    end

    // clock edges count only while select is recognised low
    wire sclkRiseEv = csLowQ && sclkSync && !sclkPrevQ;
    wire sclkFallEv = csLowQ && !sclkSync && sclkPrevQ;

    sap_state_t stateQ;
    logic [4:0] fallCntQ;
    logic [2:0] riseCntQ;
    logic       riseAfterTenQ;
    logic [3:0] addrQ;
    logic [3:0] convAddrQ;
    logic [9:0] shiftQ;
    logic [9:0] resultQ;
    logic       doutQ, oenQ, eocQ;
    sap_pkg::sap_ana_ctl_t anaQ;

    // conversion engine state
    logic       sarBusyQ, wrPendQ;
    logic [3:0] sarBitQ;
    logic [9:0] sarQ;
    logic [7:0] oscCntQ;
    logic       fifoWrReady, fifoRdValid;
    logic [9:0] fifoRdData;

    wire tenthFall = sclkFallEv && (stateQ == ST_SHIFT) && (fallCntQ == sap_pkg::FALL_TEN - 5'h01);
    wire sampleGo  = sclkFallEv && (stateQ == ST_SHIFT) && (fallCntQ == sap_pkg::FALL_SAMPLE - 5'h01);
    wire longFall  = sclkFallEv && (fallCntQ == sap_pkg::FALL_LONG - 5'h01);
    // result lands only when the fifo hands it over
    wire resultPop = fifoRdValid && (stateQ == ST_CONV);
    wire [9:0] newResult = resultPop ? fifoRdData : resultQ;
    // new msb at conversion end or 16th fall
    // a rise after the tenth fall marks a long transfer
    wire restartConvEnd = resultPop && csLowQ && (fallCntQ == sap_pkg::FALL_LONG || !riseAfterTenQ);
    wire restartLong    = (stateQ == ST_TAIL) && longFall;
    // three starts: select fall, conversion end, 16th fall
    wire restart        = csFallEv || restartConvEnd || restartLong;
    // select fall while converting abandons the conversion
    wire sarAbort       = csFallEv && (stateQ == ST_CONV);

    // one select line per analog input
    wire [sap_pkg::NUM_CHAN-1:0] chanDec;
    genvar gi;
    generate
        for (gi = 0; gi < sap_pkg::NUM_CHAN; gi++) begin : g_chan
            assign chanDec[gi] = (addrQ == 4'(gi));
        end
    endgenerate
    wire sap_pkg::sap_ref_t refDec =
        (addrQ == sap_pkg::ADDR_TEST_MID)  ? sap_pkg::REF_MID  :
        (addrQ == sap_pkg::ADDR_TEST_ZERO) ? sap_pkg::REF_LOW  :
        (addrQ == sap_pkg::ADDR_TEST_FULL) ? sap_pkg::REF_HIGH : sap_pkg::REF_NONE;

    // every state but ST_CONV holds indefinitely without clock edges
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            stateQ        <= ST_IDLE;
            fallCntQ      <= '0;
            riseCntQ      <= '0;
            riseAfterTenQ <= 1'b0;
            addrQ         <= sap_pkg::ADDR_RESET;
            convAddrQ     <= sap_pkg::ADDR_RESET;
            shiftQ        <= sap_pkg::RESULT_RESET;
            resultQ       <= sap_pkg::RESULT_RESET;
            doutQ         <= 1'b0;
            eocQ          <= 1'b1;
            anaQ          <= '0;
        end else begin
            if (resultPop)
                resultQ <= fifoRdData;
            // eoc rises once the result is ready
            if (resultPop || sarAbort)
                eocQ <= 1'b1;
            if (restart) begin
                stateQ        <= ST_SHIFT;
                fallCntQ      <= '0;
                riseCntQ      <= '0;
                riseAfterTenQ <= 1'b0;
                shiftQ        <= newResult;
                doutQ         <= newResult[9];
            end else if (csRiseEv) begin
                if (stateQ != ST_CONV)
                    stateQ <= ST_IDLE;
            end else if (resultPop) begin
                stateQ <= csLowQ ? ST_TAIL : ST_IDLE;
            end else begin
                // first four rises take the address msb first
                if (sclkRiseEv && stateQ == ST_SHIFT && riseCntQ < sap_pkg::RISE_ADDR) begin
                    addrQ    <= {addrQ[2:0], dinSync};
                    riseCntQ <= riseCntQ + 3'h1;
                end
                if (sclkRiseEv && stateQ != ST_SHIFT)
                    riseAfterTenQ <= 1'b1;
                if (sclkFallEv && fallCntQ != sap_pkg::FALL_LONG)
                    fallCntQ <= fallCntQ + 5'h01;
                if (sclkFallEv && stateQ == ST_SHIFT) begin
                    shiftQ <= {shiftQ[8:0], 1'b0};
                    doutQ  <= shiftQ[8];
                end
                // sampling window opens at fourth fall
                if (sampleGo) begin
                    anaQ.chanSel  <= chanDec;
                    anaQ.refSel   <= refDec;
                    anaQ.sampleEn <= 1'b1;
                    anaQ.hold     <= 1'b0;
                end
                if (tenthFall) begin
                    doutQ         <= 1'b0;
                    eocQ          <= 1'b0;
                    anaQ.sampleEn <= 1'b0;
                    anaQ.hold     <= 1'b1;
                    convAddrQ     <= addrQ;
                    stateQ        <= ST_CONV;
                end
            end
        end
    end

    // output floats while select is high
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn)
            oenQ <= 1'b1;
        else
            oenQ <= !csLowQ;
    end

    wire oscTick = (oscCntQ == 8'(OSC_DIV - 1));
    wire [9:0] forcedResult =
        (convAddrQ == sap_pkg::ADDR_TEST_MID)  ? sap_pkg::RESULT_MID  :
        (convAddrQ == sap_pkg::ADDR_TEST_ZERO) ? sap_pkg::RESULT_ZERO :
        (convAddrQ == sap_pkg::ADDR_TEST_FULL) ? sap_pkg::RESULT_FULL : sarQ;
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            sarBusyQ <= 1'b0;
            wrPendQ  <= 1'b0;
            sarBitQ  <= '0;
            sarQ     <= '0;
            oscCntQ  <= '0;
        end else if (sarAbort) begin
            sarBusyQ <= 1'b0;
            wrPendQ  <= 1'b0;
        end else if (tenthFall) begin
            sarBusyQ <= 1'b1;
            sarBitQ  <= 4'h9;
            sarQ     <= 10'h200;
            oscCntQ  <= '0;
        end else if (sarBusyQ && !wrPendQ) begin
            oscCntQ <= oscTick ? 8'h00 : oscCntQ + 8'h01;
            if (oscTick) begin
                sarQ[sarBitQ] <= cmpSync;
                if (sarBitQ == 4'h0)
                    wrPendQ <= 1'b1;
                else begin
                    sarQ[sarBitQ - 4'h1] <= 1'b1;
                    sarBitQ              <= sarBitQ - 4'h1;
                end
            end
        end else if (wrPendQ && fifoWrReady) begin
            // writing the result closes the conversion
            wrPendQ  <= 1'b0;
            sarBusyQ <= 1'b0;
        end
    end

    // full fifo holds the final write and keeps eoc low
    sap_fifo #(.WIDTH(sap_pkg::RES_BITS), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .wrValid (wrPendQ),
        .wrReady (fifoWrReady),
        .wrData  (forcedResult),
        .rdValid (fifoRdValid),
        .rdReady (stateQ == ST_CONV),
        .rdData  (fifoRdData)
    );

    assign serialOut    = doutQ;
    assign serialOutOeN = oenQ;
    assign eoc          = eocQ;
    assign anaCtl       = anaQ;
    assign sarTrial     = sarQ;

    // helper: cycles since hold began
    logic [10:0] convCycQ;
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn)
            convCycQ <= '0;
        else
            convCycQ <= (stateQ == ST_CONV) ? convCycQ + 11'h001 : 11'h000;
    end
    localparam int FILT_LAST = sap_pkg::CS_FILT_CYC - 1;
    localparam int CONV_LIM  = sap_pkg::CONV_MAX_CYC;

    property p_float_high;
        @(posedge clk_sys) disable iff (!rstn) !csLowQ |=> serialOutOeN;
    endproperty
    a_float_high: assert property (p_float_high) else $error("output driven while deselected");
    property p_realign;
        @(posedge clk_sys) disable iff (!rstn) csFallEv |=> (fallCntQ == 5'h00 && riseCntQ == 3'h0);
    endproperty
    a_realign: assert property (p_realign) else $error("counters not cleared on select fall");
    property p_filter;
        @(posedge clk_sys) disable iff (!rstn) $changed(csLowQ) |-> $past(filtCntQ) == 6'(FILT_LAST);
    endproperty
    a_filter: assert property (p_filter) else $error("select accepted without filter time");
    property p_tenth;
        @(posedge clk_sys) disable iff (!rstn) tenthFall |=> (!serialOut && !eoc && anaCtl.hold) ##1 !eoc;
    endproperty
    a_tenth: assert property (p_tenth) else $error("tenth fall effects missing");
    property p_sample;
        @(posedge clk_sys) disable iff (!rstn) sampleGo |=> anaCtl.sampleEn;
    endproperty
    a_sample: assert property (p_sample) else $error("sampling did not open");
    property p_addr_ignore;
        @(posedge clk_sys) disable iff (!rstn)
            (sclkRiseEv && riseCntQ == 3'h4 && !restart) |=> $stable(addrQ);
    endproperty
    a_addr_ignore: assert property (p_addr_ignore) else $error("address moved after four bits");
    property p_conv_time;
        @(posedge clk_sys) disable iff (!rstn) (stateQ == ST_CONV && fifoWrReady) |-> convCycQ < 11'(CONV_LIM);
    endproperty
    a_conv_time: assert property (p_conv_time) else $error("conversion too long");
    property p_test_mid;
        @(posedge clk_sys) disable iff (!rstn)
            (resultPop && convAddrQ == sap_pkg::ADDR_TEST_MID) |=> resultQ == sap_pkg::RESULT_MID;
    endproperty
    a_test_mid: assert property (p_test_mid) else $error("mid test value wrong");
    property p_msb_load;
        @(posedge clk_sys) disable iff (!rstn) restart |=> serialOut == $past(newResult[9]);
    endproperty
    a_msb_load: assert property (p_msb_load) else $error("msb not presented at start");
endmodule : sap_port_sequencer
`default_nettype wire

/* tb/sap_host_model.sv */
// host serial master model: select, shift clock and address line
`timescale 1ns/1ps
`default_nettype none
module sap_host_model (
    input  wire logic clk_sys,
    output logic      selectN,
    output logic      shiftClk,
    output logic      serialIn,
    input  wire logic serialOut,
    input  wire logic serialOutOeN
);
    initial begin
        selectN  = 1'b1;
        shiftClk = 1'b0;
        serialIn = 1'b0;
    end

    // idle line keeps moving so a stale level never looks like data
    always @(posedge clk_sys) begin
        if (selectN) serialIn <= ~serialIn;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : tick

    // settle margin on top of the filter, as a real host must allow for it
    task automatic select_set(input logic level);
        selectN <= level;
        tick(sap_pkg::CS_FILT_CYC + 10);
    endtask : select_set

    // short select pulse and stray clocks while deselected
    task automatic noise(input int lowCyc);
        selectN <= 1'b0;
        tick(lowCyc);
        selectN <= 1'b1;
        repeat (12) begin
            shiftClk <= ~shiftClk;
            tick(4);
        end
    endtask : noise

    // ten or sixteen clocks, optional pause after clock gapAt
    // address msb first on the first four rises; data read late in each high phase
    task automatic xfer(input logic [3:0] addr, input int nClk, input int gapAt, input int gapCyc,
                        output logic [15:0] rd, output logic oenOk);
        rd    = 16'h0000;
        oenOk = 1'b1;
        if (selectN) select_set(1'b0);
        for (int i = 0; i < nClk; i++) begin
            serialIn <= (i < 4) ? addr[3 - i] : 1'($urandom_range(0, 1));
            tick(4);
            shiftClk <= 1'b1;
            tick(4);
            rd[15 - i] = serialOut;
            oenOk      = oenOk & ~serialOutOeN;
            shiftClk <= 1'b0;
            if (i + 1 == gapAt) tick(gapCyc);
        end
        tick(4);
    endtask : xfer
endmodule : sap_host_model
`default_nettype wire

/* tb/test_sap_port_sequencer.sv */
// self-checking bench for the serial port sequencer
`timescale 1ns/1ps
`default_nettype none
module test_sap_port_sequencer;
    logic                        clk_sys;
    logic                        rstn;
    logic                        selectN;
    logic                        shiftClk;
    logic                        serialIn;
    logic                        compareIn;
    logic                        serialOut;
    logic                        serialOutOeN;
    logic                        eoc;
    sap_pkg::sap_ana_ctl_t       anaCtl;
    logic [sap_pkg::RES_BITS-1:0] sarTrial;
    logic [6:0]                  selSeen;
    logic                        oeLowSeen;
    int                          sampleCnt;
    int                          miscompares;
    int                          checked;
    logic [9:0]                  lastRes;
    logic                        known;

    // slow oscillator so an abort can land well inside a conversion
    sap_port_sequencer #(.OSC_DIV(40)) sap_port_sequencer_inst (
        .clk_sys(clk_sys), .rstn(rstn), .selectN(selectN), .shiftClk(shiftClk), .serialIn(serialIn),
        .compareIn(compareIn), .serialOut(serialOut), .serialOutOeN(serialOutOeN), .eoc(eoc),
        .anaCtl(anaCtl), .sarTrial(sarTrial));
    sap_host_model sap_host_model_inst (
        .clk_sys(clk_sys), .selectN(selectN), .shiftClk(shiftClk), .serialIn(serialIn),
        .serialOut(serialOut), .serialOutOeN(serialOutOeN));

    initial clk_sys = 1'b0;
    always #25 clk_sys = ~clk_sys;

    always @(posedge clk_sys) begin
        compareIn <= 1'($urandom_range(0, 1));
        if (!serialOutOeN) oeLowSeen <= 1'b1;
        if (anaCtl.sampleEn) begin
            selSeen   <= {anaCtl.refSel, anaCtl.chanSel};
            sampleCnt <= sampleCnt + 1;
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : wrap_up

    // one transfer plus its conversion, checked against the expected input select per address and the previous transfer's result
    task automatic run(input logic [3:0] addr, input int nClk, input int gapAt, input int gapCyc,
                       input bit keepLow);
        logic [15:0] rd;
        logic        oenOk;
        logic [6:0]  expSel;
        logic [9:0]  expRes;
        int          waitCnt;
        expRes = '0;
        case (addr)
            4'hB: begin expSel = {sap_pkg::REF_MID, 5'h00}; expRes = sap_pkg::RESULT_MID; end
            4'hC: begin expSel = {sap_pkg::REF_LOW, 5'h00}; expRes = sap_pkg::RESULT_ZERO; end
            4'hD: begin expSel = {sap_pkg::REF_HIGH, 5'h00}; expRes = sap_pkg::RESULT_FULL; end
            default: expSel = {sap_pkg::REF_NONE, 5'(5'h01 << addr)};
        endcase
        sampleCnt = 0;
        sap_host_model_inst.xfer(addr, nClk, gapAt, gapCyc, rd, oenOk);
        if (known) check({6'h00, rd[15:6]}, {6'h00, lastRes}, "previous result");
        check({15'h0000, oenOk}, 16'h0001, "output driven while selected");
        if (nClk == 16) check({10'h000, rd[5:0]}, 16'h0000, "trailing zeros");
        check({9'h000, selSeen}, {9'h000, expSel}, "input select");
        if (gapAt == 0 || gapAt >= 10) check(16'(sampleCnt), 16'd48, "sample window");
        if (gapCyc == 0) check({15'h0000, eoc}, 16'h0000, "eoc low after tenth fall");
        waitCnt = 0;
        while (eoc !== 1'b1 && waitCnt <= sap_pkg::CONV_MAX_CYC) begin
            @(posedge clk_sys);
            waitCnt++;
        end
        check({15'h0000, eoc}, 16'h0001, "eoc high at conversion end");
        lastRes = expRes;
        known   = (addr >= 4'hB);
        if (!keepLow) sap_host_model_inst.select_set(1'b1);
        $display("test done: address %h clocks %0d pause %0d", addr, nClk, gapCyc);
    endtask : run

    initial begin
        logic [15:0] rd;
        logic        oenOk;
        rstn        = 1'b0;
        compareIn   = 1'b0;
        oeLowSeen   = 1'b0;
        selSeen     = '0;
        sampleCnt   = 0;
        miscompares = 0;
        checked     = 0;
        lastRes     = sap_pkg::RESULT_RESET;
        known       = 1'b1;
        void'($urandom(32'hB33C10EE));
        repeat (2) @(posedge clk_sys);
        rstn <= 1'b1;
        repeat (2) @(posedge clk_sys);
        check({sarTrial, serialOut, serialOutOeN, eoc, 3'h0}, 16'h0018, "reset outputs");
        check({7'h00, anaCtl}, 16'h0000, "reset analog controls");
        oeLowSeen <= 1'b0;
        sap_host_model_inst.noise(20);
        check({14'h0000, oeLowSeen, eoc}, 16'h0001, "glitch and stray clocks ignored");
        run(4'hB, 10, 0, 0, 0);
        run(4'hC, 16, 0, 0, 0);
        run(4'hD, 16, 8, 40, 0);
        run(4'hC, 10, 5, 1500, 0);
        // only defined channel codes are sent
        for (int ch = 0; ch < sap_pkg::NUM_CHAN; ch++) run(4'(ch), 10, 0, 0, 0);
        // select held low: restart at conversion end, then at the 16th fall
        run(4'hD, 10, 0, 0, 1);
        run(4'hC, 16, 0, 0, 1);
        run(4'hB, 16, 11, 600, 1);
        run(4'hD, 10, 0, 0, 0);
        // abort early in the conversion, far from the result write
        sap_host_model_inst.xfer(4'($urandom_range(0, 4)), 10, 0, 0, rd, oenOk);
        check({6'h00, rd[15:6]}, {6'h00, lastRes}, "result before abort");
        sap_host_model_inst.select_set(1'b1);
        sap_host_model_inst.select_set(1'b0);
        check({15'h0000, eoc}, 16'h0001, "abort returns eoc high");
        run(4'hB, 10, 0, 0, 0);
        wrap_up();
    end

    initial begin
        repeat (40000) @(posedge clk_sys);
        miscompares++;
        wrap_up();
    end
endmodule : test_sap_port_sequencer
`default_nettype wire
